// *** logic/expander_cfg.svh ***
`ifndef EXPANDER_CFG_SVH
`define EXPANDER_CFG_SVH

// frame layout
`define ADDR_BITS 8
`define PORT_BITS 16
`define FRAME_BITS 24
`define BIT_CNT_W 5
// address 15 is kept for the broadcast trigger
`define ADDR_MAX_VALID 8'h0E
`define ADDR_DEFAULT 4'h0
// controller divides mclk by twice this half period to make the shift clock
`define HALF_PERIOD 4'h4
`define HALF_CNT_W 4

`endif

// *** logic/expander_pkg.sv ***
`default_nettype none
package expander_pkg;
	typedef logic [15:0] port_word_t;
	typedef logic [3:0] switch_addr_t;
	typedef enum logic [1:0] {
		RX_ADDR = 2'b00,
		RX_DATA = 2'b01,
		RX_SKIP = 2'b10,
		RX_DONE = 2'b11
	} rx_state_t;
	typedef enum logic [2:0] {
		TX_IDLE = 3'b000,
		TX_START = 3'b001,
		TX_LOW = 3'b010,
		TX_HIGH = 3'b011,
		TX_LATCH = 3'b100,
		TX_REARM = 3'b101,
		TX_CLOSE = 3'b110
	} tx_state_t;
endpackage
`default_nettype wire

// *** logic/expander_link_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface expander_link_if;
	logic serialDataLine;
	logic shiftClockLine;
	logic selectLine;
	modport controller (
		output serialDataLine,
		output shiftClockLine,
		output selectLine
	);
	modport expander (
		input serialDataLine,
		input shiftClockLine,
		input selectLine
	);
endinterface
`default_nettype wire

// *** logic/port_expander.sv ***
`include "expander_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
// How it works
// - outputs low after power-up
// - controller raises clock and select to start
// - controller shifts LSB first on falling edges
// - sample data on rising clock, select high
// - first eight bits are the address
// - only matching address enables data capture
// - next sixteen bits map to outputs 1..16
// - select low pulse, clock high, latches outputs
// - controller drops select and clock to close
// - bit one drives output high, zero low
// - controller uses addresses 0..14 only
// - several modules get consecutive addresses
// - addresses written as two base-4 digits
// - own address from sixteen-position switch
module port_expander (
	// link, clocked by the shift clock
	expander_link_if.expander link,
	// power-on reset and address switch
	input wire logic rst,
	input wire expander_pkg::switch_addr_t switchAddr,
	// output ports, bit 0 is output 1
	output var expander_pkg::port_word_t portOut
);
	import expander_pkg::*;

	typedef struct packed {
		rx_state_t state;
		logic [`BIT_CNT_W-1:0] count;
		logic [`ADDR_BITS-1:0] addr;
		port_word_t shift;
		logic matched;
	} rx_t;

	typedef struct packed {
		port_word_t outs;
	} lat_t;

	rx_t rx_ff, nxt_rx;
	lat_t lat_ff, nxt_lat;
	logic [`ADDR_BITS-1:0] ownAddr;
	logic [`ADDR_BITS-1:0] fullAddr;

	// =========================================
	// receive, rising shift clock
	// switch value is the address itself; base-4 display is only notation
	assign ownAddr = {4'h0, switchAddr};

	always_comb begin
		nxt_rx = rx_ff;
		fullAddr = {link.serialDataLine, rx_ff.addr[`ADDR_BITS-1:1]};
		if (!link.selectLine) begin
			// select low outside a frame restarts address reception
			nxt_rx.state = RX_ADDR;
			nxt_rx.count = '0;
		end else begin
			unique case (rx_ff.state)
				RX_ADDR: begin
					nxt_rx.addr = fullAddr;
					nxt_rx.count = rx_ff.count + 5'h01;
					if (rx_ff.count == 5'(`ADDR_BITS - 1)) begin
						nxt_rx.count = '0;
						nxt_rx.matched = (fullAddr == ownAddr);
						nxt_rx.state = (fullAddr == ownAddr) ? RX_DATA : RX_SKIP;
					end
				end
				RX_DATA: begin
					// LSB first, so first bit ends in bit 0 = output 1
					nxt_rx.shift = {link.serialDataLine, rx_ff.shift[`PORT_BITS-1:1]};
					nxt_rx.count = rx_ff.count + 5'h01;
					if (rx_ff.count == 5'(`PORT_BITS - 1)) begin
						nxt_rx.state = RX_DONE;
					end
				end
				RX_SKIP: nxt_rx.matched = 1'b0;
				RX_DONE: nxt_rx.state = RX_DONE;
			endcase
		end
	end

	// the shift clock idles low through reset, so the receiver clears without it
	always_ff @(posedge link.shiftClockLine or posedge rst) begin
		if (rst) begin
			rx_ff <= '{state: RX_ADDR, count: '0, addr: '0, shift: '0, matched: 1'b0};
		end else begin
			rx_ff <= nxt_rx;
		end
	end

	// =========================================
	// latch on the rising edge that ends the select low pulse
	// clock is held high during the pulse, so data is stable here
	always_comb begin
		nxt_lat = lat_ff;
		if (link.shiftClockLine && rx_ff.matched && rx_ff.state == RX_DONE) begin
			nxt_lat.outs = rx_ff.shift;
		end
	end

	always_ff @(posedge link.selectLine or posedge rst) begin
		if (rst) begin
			lat_ff <= '{outs: '0};
		end else begin
			lat_ff <= nxt_lat;
		end
	end

	assign portOut = lat_ff.outs;

endmodule
`default_nettype wire

// *** logic/port_controller.sv ***
`include "expander_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module port_controller (
	// system
	input wire logic mclk,
	input wire logic rst,
	// request: write portWord to module startAddr
	input wire logic reqValid,
	output logic reqReady,
	input wire logic [7:0] startAddr,
	input wire expander_pkg::port_word_t portWord,
	output logic busy,
	// link
	expander_link_if.controller link
);
	import expander_pkg::*;

	typedef struct packed {
		tx_state_t state;
		logic [`HALF_CNT_W-1:0] half;
		logic [`BIT_CNT_W-1:0] bitNo;
		logic [`FRAME_BITS-1:0] frame;
		logic sclk;
		logic sel;
		logic sdat;
	} tx_t;

	tx_t tx_ff, nxt_tx;
	logic halfDone;

	assign halfDone = (tx_ff.half == `HALF_PERIOD - 4'h1);
	// addresses above 14 are refused; 15 is the broadcast trigger
	assign reqReady = (tx_ff.state == TX_IDLE) && (startAddr <= `ADDR_MAX_VALID);
	assign busy = (tx_ff.state != TX_IDLE);

	// =========================================
	// frame sequencer; shift clock is mclk divided by twice HALF_PERIOD
	always_comb begin
		nxt_tx = tx_ff;
		nxt_tx.half = halfDone ? '0 : tx_ff.half + 4'h1;
		unique case (tx_ff.state)
			TX_IDLE: begin
				nxt_tx.half = '0;
				if (reqValid && reqReady) begin
					// consecutive modules are done by issuing further requests
					nxt_tx.frame = {portWord, startAddr};
					// clock rises first with select low: the receiver restarts on it
					// and no clock edge races the select edge
					nxt_tx.sclk = 1'b1;
					nxt_tx.bitNo = '0;
					nxt_tx.state = TX_START;
				end
			end
			TX_START: if (halfDone) begin
				if (!tx_ff.sel) begin
					nxt_tx.sel = 1'b1;
				end else begin
					nxt_tx.sclk = 1'b0;
					nxt_tx.sdat = tx_ff.frame[0];
					nxt_tx.state = TX_LOW;
				end
			end
			TX_LOW: if (halfDone) begin
				nxt_tx.sclk = 1'b1;
				nxt_tx.state = TX_HIGH;
			end
			TX_HIGH: if (halfDone) begin
				nxt_tx.frame = {1'b0, tx_ff.frame[`FRAME_BITS-1:1]};
				nxt_tx.bitNo = tx_ff.bitNo + 5'h01;
				if (tx_ff.bitNo == 5'(`FRAME_BITS - 1)) begin
					nxt_tx.sel = 1'b0;
					nxt_tx.state = TX_LATCH;
				end else begin
					// data changes on the falling edge, LSB first
					nxt_tx.sclk = 1'b0;
					nxt_tx.sdat = tx_ff.frame[1];
					nxt_tx.state = TX_LOW;
				end
			end
			TX_LATCH: if (halfDone) begin
				nxt_tx.sel = 1'b1;
				nxt_tx.state = TX_REARM;
			end
			TX_REARM: if (halfDone) begin
				nxt_tx.sel = 1'b0;
				nxt_tx.sclk = 1'b0;
				nxt_tx.sdat = 1'b0;
				nxt_tx.state = TX_CLOSE;
			end
			TX_CLOSE: if (halfDone) begin
				nxt_tx.state = TX_IDLE;
			end
			default: nxt_tx.state = TX_IDLE;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			tx_ff <= '{state: TX_IDLE, half: '0, bitNo: '0, frame: '0,
				sclk: 1'b0, sel: 1'b0, sdat: 1'b0};
		end else begin
			tx_ff <= nxt_tx;
		end
	end

	assign link.shiftClockLine = tx_ff.sclk;
	assign link.selectLine = tx_ff.sel;
	assign link.serialDataLine = tx_ff.sdat;

endmodule
`default_nettype wire

// *** test/serial_output_port_expander_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module serial_output_port_expander_monitor (
	// system
	input wire logic mclk,
	input wire logic rst,
	// link and outputs
	input wire logic serialDataLine,
	input wire logic shiftClockLine,
	input wire logic selectLine,
	input wire expander_pkg::port_word_t portOut
);
	import expander_pkg::*;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// ========================================
	// framing seen from mclk
	sequence latch_s;
		(shiftClockLine && !selectLine)[*4] ##1 (selectLine && shiftClockLine)[*4]
			##1 (!selectLine && !shiftClockLine);
	endsequence
	start_clk_a: assert property ($rose(selectLine) |-> shiftClockLine)
		else $error("frame start with clock low");
	clk_in_frame_a: assert property ($rose(shiftClockLine) |-> selectLine or ##4 $rose(selectLine))
		else $error("clock edge outside frame");
	half_period_a: assert property ($rose(shiftClockLine) |-> shiftClockLine[*4])
		else $error("clock high too short");
	data_edge_a: assert property (selectLine && $past(selectLine) && $changed(serialDataLine)
		|-> $fell(shiftClockLine)) else $error("data moved off falling edge");
	frame_len_a: assert property ($rose(selectLine) && !$past(selectLine, 5)
		|-> ##4 $fell(shiftClockLine) ##192 $fell(selectLine)) else $error("frame length");
	latch_pulse_a: assert property ($fell(selectLine) && shiftClockLine |-> latch_s)
		else $error("latch pulse shape");
	outputs_hold_a: assert property ($changed(portOut) |-> $rose(selectLine))
		else $error("outputs moved without latch");
	reset_low_a: assert property (disable iff (1'b0) rst |-> portOut == 16'h0000)
		else $error("outputs not low in reset");
endmodule
`default_nettype wire

// *** test/serial_output_port_expander_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module serial_output_port_expander_tb_top;
	import expander_pkg::*;
	logic mclk = 1'b0;
	logic rst;
	logic reqValid = 1'b0;
	logic reqReady;
	logic busy;
	logic [7:0] startAddr = 8'h00;
	port_word_t portWord = 16'h0000;
	port_word_t portOut;
	switch_addr_t switchAddr = 4'h5;
	logic [23:0] cap = 24'h000000;
	int bitCount = 0;
	int badCount = 0;
	int checks = 0;
	int cycles = 0;
	expander_link_if link ();
	port_controller i_port_controller (.mclk(mclk), .rst(rst), .reqValid(reqValid),
		.reqReady(reqReady), .startAddr(startAddr), .portWord(portWord), .busy(busy),
		.link(link));
	port_expander i_port_expander (.link(link), .rst(rst), .switchAddr(switchAddr),
		.portOut(portOut));
	serial_output_port_expander_monitor i_monitor (.mclk(mclk), .rst(rst),
		.serialDataLine(link.serialDataLine), .shiftClockLine(link.shiftClockLine),
		.selectLine(link.selectLine), .portOut(portOut));
	// ========================================
	// clock, wire capture and hang guard
	initial begin
		forever #25 mclk = ~mclk;
	end
	always @(posedge link.shiftClockLine) begin
		if (link.selectLine) begin
			cap <= {link.serialDataLine, cap[23:1]};
			bitCount <= bitCount + 1;
		end
	end
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			badCount++;
			results();
		end
	end
	task automatic check(input string what, input logic [23:0] exp, input logic [23:0] seen);
		checks++;
		if (seen !== exp) begin
			badCount++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// one frame; wire bits are compared with what the controller should have sent
	task automatic send(input logic [7:0] addr, input port_word_t word, input port_word_t expOut);
		bitCount = 0;
		@(posedge mclk);
		reqValid <= 1'b1;
		startAddr <= addr;
		portWord <= word;
		@(posedge mclk);
		while (reqReady !== 1'b1) @(posedge mclk);
		reqValid <= 1'b0;
		repeat (2) @(posedge mclk);
		while (busy === 1'b1) @(posedge mclk);
		check("outputs", 24'(expOut), 24'(portOut));
		check("bit count", 24'd24, 24'(bitCount));
		check("wire bits", {word, addr}, cap);
	endtask
	task automatic results();
		$display("checks %0d errors %0d", checks, badCount);
		if (badCount == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// ========================================
	// tests
	initial begin
		rst <= 1'b1;
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		check("outputs after reset", 24'd0, 24'(portOut));
		send(8'h05, 16'hA5C3, 16'hA5C3);
		send(8'h06, 16'hFFFF, 16'hA5C3);
		send(8'h04, 16'h0000, 16'hA5C3);
		send(8'h05, 16'h8001, 16'h8001);
		send(8'h05, 16'h8001, 16'h8001);
		@(posedge mclk);
		reqValid <= 1'b1;
		startAddr <= 8'h0F;
		repeat (4) @(posedge mclk);
		check("ready for reserved address", 24'd0, 24'(reqReady));
		reqValid <= 1'b0;
		switchAddr <= 4'hE;
		send(8'h0E, 16'h7FFE, 16'h7FFE);
		results();
	end
endmodule
`default_nettype wire
